// *** inc/global_configuration_pkg.sv ***
// constants for the global configuration and diagnostic routing block
// Function
// - recalibrate zero crossing while driver disabled
// - standstill after 2^18 or 2^20 idle clocks
// - bit 2 enables quiet voltage pwm mode
// - bit 3 step filtering, resets to one
// - bit 4 reverses motor direction
// - bit 5 routes driver faults to pin a
// - pin a active low during reset
// - bit 6 routes heat prewarning to pin a
// - bit 7 routes stall to pin a
// - bit 8 routes stall to pin b
// - bit 9 routes table zero to pin b
// - bit 10 routes chopper on to pin b
// - bit 11 toggles pin b per lost step
// - bit 12 selects pin a drive type
// - bit 13 selects pin b drive type
`default_nettype none
package global_configuration_pkg;
  localparam logic [6:0]  global_configuration_addr = 7'h00;
  localparam logic [7:0]  write_flag                = 8'h80;
  localparam int          config_width              = 17;
  localparam logic [16:0] config_reset              = 17'h00008;
  localparam int recalibrate_bit     = 0;
  localparam int fast_standstill_bit = 1;
  localparam int pwm_mode_bit        = 2;
  localparam int step_filter_bit     = 3;
  localparam int reverse_bit         = 4;
  localparam int pin_a_on_driver_fault_bit     = 5;
  localparam int pin_a_on_heat_prewarn_bit     = 6;
  localparam int pin_a_on_stall_bit            = 7;
  localparam int pin_b_on_stall_bit            = 8;
  localparam int pin_b_on_table_zero_bit       = 9;
  localparam int pin_b_on_chopper_on_bit       = 10;
  localparam int pin_b_toggle_on_lost_step_bit = 11;
  localparam int pin_a_push_pull_select_bit    = 12;
  localparam int pin_b_push_pull_select_bit    = 13;
  localparam int fast_standstill_log2   = 18;
  localparam int normal_standstill_log2 = 20;
  localparam int idle_width             = 21;
endpackage
`default_nettype wire

// *** rtl/idle_timer.sv ***
// step idle timer raising standstill
`default_nettype none
module idle_timer
  import global_configuration_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic step_done,
  input  wire logic fast,
  output var  logic standstill
);
  typedef struct packed
  {
    logic [idle_width-1:0] count;
    logic                  still;
  } state_s;
  state_s state;
  state_s next_state;
  logic [idle_width-1:0] limit;

  always_comb
  begin
    next_state = state;
    limit = fast ? idle_width'(1 << fast_standstill_log2)
                 : idle_width'(1 << normal_standstill_log2);
    if (step_done)
    begin
      next_state.count = '0;
      next_state.still = 1'b0;
    end
    else if (state.count >= limit - idle_width'(1))
      next_state.still = 1'b1;
    else
      next_state.count = state.count + idle_width'(1);
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      state <= '0;
    else
      state <= next_state;
  end

  assign standstill = state.still;
endmodule
`default_nettype wire

// *** rtl/global_config_diag_routing.sv ***
// global configuration register and diagnostic pin routing
`default_nettype none
module global_config_diag_routing
  import global_configuration_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_address,
  input  wire logic [31:0] cmd_write_data,
  output logic [31:0]      read_data,
  input  wire logic        driver_disable_pin,
  input  wire logic [3:0]  chopper_off_time,
  input  wire logic        step_done,
  input  wire logic        direction_in,
  input  wire logic        overtemperature_fault,
  input  wire logic        short_to_ground_fault,
  input  wire logic        charge_pump_undervoltage,
  input  wire logic        heat_prewarn,
  input  wire logic        stall,
  input  wire logic        table_zero,
  input  wire logic        chopper_on,
  input  wire logic        lost_step,
  output logic             recalibrate_now,
  output logic             standstill,
  output logic             pwm_mode_enable,
  output logic             step_filter_enable,
  output logic             motor_direction,
  output logic             diagnostic_pin_a_out,
  output logic             diagnostic_pin_a_oe,
  output logic             diagnostic_pin_b_out,
  output logic             diagnostic_pin_b_oe
);
  typedef struct packed
  {
    logic [config_width-1:0] global_configuration;
    logic [31:0]             read_data;
    logic                    recal;
    logic                    pwm;
    logic                    filt;
    logic                    dir;
    logic                    toggle;
    logic                    a_out;
    logic                    a_oe;
    logic                    b_out;
    logic                    b_oe;
  } state_s;
  state_s state;
  state_s next_state;
  logic   a_active;
  logic   b_active;
  logic   driver_off;
  logic [config_width-1:0] g;

  idle_timer idle
  (
    .clock      (clock),
    .resetn     (resetn),
    .step_done  (step_done),
    .fast       (state.global_configuration[fast_standstill_bit]),
    .standstill (standstill)
  );

  always_comb
  begin
    next_state = state;
    if (cmd_valid && cmd_address[6:0] == global_configuration_addr)
    begin
      if (cmd_address[7])
        next_state.global_configuration =
          cmd_write_data[config_width-1:0];
      else
        next_state.read_data = {15'h0000, state.global_configuration};
    end
    g = next_state.global_configuration;
    driver_off = driver_disable_pin || (chopper_off_time == 4'h0);
    next_state.recal = g[recalibrate_bit] && driver_off;
    next_state.pwm = g[pwm_mode_bit];
    next_state.filt = g[step_filter_bit];
    next_state.dir = direction_in ^ g[reverse_bit];
    if (lost_step)
      next_state.toggle = ~state.toggle;
    a_active = (g[pin_a_on_driver_fault_bit]
                && (overtemperature_fault || short_to_ground_fault
                    || charge_pump_undervoltage))
               || (g[pin_a_on_heat_prewarn_bit] && heat_prewarn)
               || (g[pin_a_on_stall_bit] && stall);
    b_active = (g[pin_b_on_stall_bit] && stall)
               || (g[pin_b_on_table_zero_bit] && table_zero)
               || (g[pin_b_on_chopper_on_bit] && chopper_on)
               || (g[pin_b_toggle_on_lost_step_bit]
                   && next_state.toggle);
    if (g[pin_a_push_pull_select_bit])
    begin
      next_state.a_out = a_active;
      next_state.a_oe = 1'b1;
    end
    else
    begin
      next_state.a_out = 1'b0;
      next_state.a_oe = a_active;
    end
    if (g[pin_b_push_pull_select_bit])
    begin
      next_state.b_out = b_active;
      next_state.b_oe = 1'b1;
    end
    else
    begin
      next_state.b_out = 1'b0;
      next_state.b_oe = b_active;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state <= '0;
      state.global_configuration <= config_reset;
      state.filt <= 1'b1;
      state.a_oe <= 1'b1;
    end
    else
      state <= next_state;
  end

  assign read_data = state.read_data;
  assign recalibrate_now = state.recal;
  assign pwm_mode_enable = state.pwm;
  assign step_filter_enable = state.filt;
  assign motor_direction = state.dir;
  assign diagnostic_pin_a_out = state.a_out;
  assign diagnostic_pin_a_oe = state.a_oe;
  assign diagnostic_pin_b_out = state.b_out;
  assign diagnostic_pin_b_oe = state.b_oe;
endmodule
`default_nettype wire

// *** test/global_configuration_sva.sv ***
// checker for the global configuration block
`default_nettype none
module global_configuration_sva
  import global_configuration_pkg::*;
(
  input wire logic clock, resetn, cmd_valid, driver_disable_pin,
  input wire logic direction_in, lost_step, stall, heat_prewarn,
  input wire logic overtemperature_fault, short_to_ground_fault,
  input wire logic charge_pump_undervoltage, table_zero, chopper_on,
  input wire logic recalibrate_now, pwm_mode_enable, step_filter_enable,
  input wire logic motor_direction, diagnostic_pin_a_out,
  input wire logic diagnostic_pin_a_oe, diagnostic_pin_b_out,
  input wire logic diagnostic_pin_b_oe,
  input wire logic [3:0] chopper_off_time,
  input wire logic [7:0] cmd_address,
  input wire logic [31:0] cmd_write_data, read_data
);
  logic [16:0] cfg;
  logic [4:0] src;
  wire act_a = |(src[2:0] & cfg[7:5]);
  wire act_b = |(src[4:2] & cfg[10:8]);
  always_ff @(posedge clock)
  begin
    src <= {chopper_on, table_zero, stall, heat_prewarn,
      overtemperature_fault | short_to_ground_fault | charge_pump_undervoltage};
    if (!resetn)
      cfg <= config_reset;
    else if (cmd_valid && cmd_address == 8'h80)
      cfg <= cmd_write_data[16:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence live; $past(resetn); endsequence
  sequence lost_pulse; lost_step && cfg[11] && cfg[13]; endsequence
  reset_a: assert property (disable iff (1'b0) !resetn |=>
    diagnostic_pin_a_oe && !diagnostic_pin_a_out) else $error("pin a reset");
  dir_a: assert property (live |->
    motor_direction == ($past(direction_in) ^ cfg[4])) else $error("dir");
  mode_a: assert property (live |-> pwm_mode_enable == cfg[2] &&
    step_filter_enable == cfg[3]) else $error("mode bits");
  recal_a: assert property (live |-> recalibrate_now == (cfg[0] &&
    ($past(driver_disable_pin) || $past(chopper_off_time) == 4'h0)))
    else $error("recal");
  pin_a_a: assert property (live |->
    diagnostic_pin_a_out == (cfg[12] && act_a) &&
    diagnostic_pin_a_oe == (cfg[12] || act_a)) else $error("pin a");
  pin_b_a: assert property ($past(resetn) && !cfg[11] |->
    diagnostic_pin_b_out == (cfg[13] && act_b) &&
    diagnostic_pin_b_oe == (cfg[13] || act_b)) else $error("pin b");
  lost_toggle_a: assert property (lost_pulse |->
    ##[1:2] $changed(diagnostic_pin_b_out)) else $error("toggle");
  readback_a: assert property (cmd_valid && cmd_address == 8'h00 |=>
    read_data == {15'h0, cfg}) else $error("read");
endmodule
bind global_config_diag_routing global_configuration_sva global_configuration_sva_i (.*);
`default_nettype wire

// *** test/diag_host.sv ***
// host view of the two diagnostic pins with pull-ups
`default_nettype none
module diag_host
(
  input wire logic a_out, a_oe, b_out, b_oe,
  output wire logic pin_a, pin_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // released open collector lines float up
  assign pin_a = a_oe ? a_out : 1'b1;
  assign pin_b = b_oe ? b_out : 1'b1;
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// testbench for the global configuration block
`default_nettype none
module tb_top
  import global_configuration_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, resetn = 0, cmd_valid = 0, driver_disable_pin = 0;
  logic step_done = 0, direction_in = 0, lost_step = 0;
  logic [7:0] cmd_address = 8'h00;
  logic [31:0] cmd_write_data = 32'h0, read_data;
  logic [6:0] s = 7'h00;
  logic [3:0] chopper_off_time = 4'h1;
  logic recalibrate_now, standstill, pwm_mode_enable, step_filter_enable;
  logic motor_direction, pin_a, pin_b, ao, aoe, bo, boe;
  logic [16:0] en [7] = '{17'h20, 17'h20, 17'h20, 17'h40, 17'h180, 17'h200,
    17'h400};
  int num_errors = 0, checks = 0, cycles = 0;
  always #2.5 clock = ~clock;
  global_config_diag_routing global_config_diag_routing_i (.*,
    .overtemperature_fault(s[0]), .short_to_ground_fault(s[1]),
    .charge_pump_undervoltage(s[2]), .heat_prewarn(s[3]), .stall(s[4]),
    .table_zero(s[5]), .chopper_on(s[6]), .diagnostic_pin_a_out(ao),
    .diagnostic_pin_a_oe(aoe), .diagnostic_pin_b_out(bo),
    .diagnostic_pin_b_oe(boe));
  diag_host diag_host_i (.a_out(ao), .a_oe(aoe), .b_out(bo), .b_oe(boe),
    .pin_a, .pin_b);
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmd(logic [7:0] a, logic [31:0] d);
    @(negedge clock) {cmd_valid, cmd_address, cmd_write_data} = {1'b1, a, d};
    @(negedge clock) cmd_valid = 0;
  endtask
  task automatic wr(logic [16:0] d);
    cmd(write_flag | global_configuration_addr, {15'h0, d});
  endtask
  task automatic rd(logic [16:0] e);
    cmd({1'b0, global_configuration_addr}, 32'h0);
    chk("read_data", {15'h0, e}, read_data);
  endtask
  task automatic close_out;
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      close_out;
    end
  end
  initial
  begin
    repeat (16) @(negedge clock);
    chk("pin_a", 1'b0, pin_a);
    resetn = 1;
    rd(config_reset);
    for (int k = 0; k < 14; k++)
    begin
      s = 7'h01 << (k % 7);
      wr(en[k % 7] | (k > 6 ? 17'h3000 : 17'h0));
      @(negedge clock);
      chk("pin_a", k % 7 < 5 ^ k < 7, pin_a);
      chk("pin_b", k % 7 > 3 ^ k < 7, pin_b);
    end
    {s, direction_in, driver_disable_pin} = 9'h003;
    wr(17'h1d);
    @(negedge clock);
    chk("outputs", 4'he, {recalibrate_now, pwm_mode_enable,
      step_filter_enable, motor_direction});
    {driver_disable_pin, chopper_off_time} = 5'h00;
    repeat (2) @(negedge clock);
    chk("recal", 1'b1, recalibrate_now);
    cmd(8'h81, 32'h0);
    cmd(8'h01, 32'h0);
    chk("read_data", {15'h0, config_reset}, read_data);
    rd(17'h1d);
    wr(17'h2800);
    for (int i = 1; i < 3; i++)
    begin
      @(negedge clock) {lost_step, step_done} = 2'b11;
      @(negedge clock) {lost_step, step_done} = 2'b00;
      repeat (2) @(negedge clock);
      chk("pin_b", i % 2, pin_b);
    end
    chk("standstill", 1'b0, standstill);
    resetn = 0;
    repeat (2) @(negedge clock);
    chk("pin_a", 1'b0, pin_a);
    resetn = 1;
    rd(config_reset);
    chk("pin_b", 1'b1, pin_b);
    close_out;
  end
endmodule
`default_nettype wire
